// ==== verilog/adrs_status.sv ====
// Purpose: Data-ready status register of the accelerometer axes
// Assumes: Reads are one-cycle strobes; answers one cycle later
// Notes: Status register view lags flag updates by one cycle
//
// Summary of operation
// - Status visible at 0x00 only in mode 0
// - Bits: overwrites 7..4, ready 3..0, reset 0
// - Combined overwrite set when any axis overwritten
// - Combined overwrite cleared after all high reads
// - Z overwrite on unread replace, cleared reading
// - Y overwrite on unread replace, cleared reading
// - X overwrite on unread replace, cleared reading
// - Combined ready set on any new sample
// - Combined ready cleared after all high reads
// - Z ready set on sample, cleared on read
// - Y ready set on sample, cleared on read
// - X ready set on sample, cleared on read
`timescale 1ns/1ps
module adrs_status (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Acquisition events, one bit per axis
  input wire logic [adrs_pkg::ADRS_NUM_AXES-1:0] acq_done_in,
  // Output mode selector
  input wire logic [1:0] fifo_mode_in,
  // Register read port
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_addr_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  // Status view
  output logic [7:0] status_out,
  output logic status_live_out
);
  import adrs_pkg::*;

  localparam int NA = ADRS_NUM_AXES;
  localparam logic [7:0] HI_ADDR [NA] =
    '{ADRS_OUT_X_HI_ADDR, ADRS_OUT_Y_HI_ADDR, ADRS_OUT_Z_HI_ADDR};

  logic [NA-1:0] hi_rd;
  logic [NA-1:0] ready_flag;
  logic [NA-1:0] over_flag;
  logic [NA-1:0] over_evt;
  logic [NA-1:0] rd_seen;
  logic [NA-1:0] next_rd_seen;
  logic all_ready;
  logic all_over;
  logic any_acq;
  logic any_over;
  logic all_read;
  logic mode_off;
  logic status_hit;
  logic [7:0] status_vec;

  // ----------------------------------------------------------------
  // Per-axis flags
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NA; i++)
    begin : g_axis
      assign hi_rd[i] = rd_strobe_in && (rd_addr_in == HI_ADDR[i]);
      adrs_axis_flag u_flag (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .acq_in(acq_done_in[i]),
        .hi_rd_in(hi_rd[i]),
        .ready_out(ready_flag[i]),
        .over_out(over_flag[i]),
        .over_evt_out(over_evt[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Combined flags and read tracking
  // ----------------------------------------------------------------
  assign any_acq = |acq_done_in;
  assign any_over = |over_evt;
  assign next_rd_seen = rd_seen | hi_rd;
  assign all_read = &next_rd_seen;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rd_seen <= ADRS_SEEN_RST;
    else if (any_acq)
      rd_seen <= ADRS_SEEN_RST;
    else if (all_read)
      rd_seen <= ADRS_SEEN_RST;
    else
      rd_seen <= next_rd_seen;
  end

  // New sample beats a completing read in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      all_ready <= 1'b0;
    else if (any_acq)
      all_ready <= 1'b1;
    else if (all_read)
      all_ready <= 1'b0;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      all_over <= 1'b0;
    else if (any_over)
      all_over <= 1'b1;
    else if (all_read)
      all_over <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Register view and read answer
  // ----------------------------------------------------------------
  always_comb
  begin
    status_vec = ADRS_STATUS_RST;
    status_vec[ADRS_BIT_READY_LO +: NA] = ready_flag;
    status_vec[ADRS_BIT_ALL_READY] = all_ready;
    status_vec[ADRS_BIT_OVER_LO +: NA] = over_flag;
    status_vec[ADRS_BIT_ALL_OVER] = all_over;
  end

  assign mode_off = (fifo_mode_in == ADRS_FMODE_OFF);
  assign status_hit = (rd_addr_in == ADRS_STATUS_ADDR) && mode_off;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      status_out <= ADRS_STATUS_RST;
    else
      status_out <= status_vec;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      status_live_out <= 1'b0;
    else
      status_live_out <= mode_off;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rd_valid_out <= 1'b0;
    else
      rd_valid_out <= rd_strobe_in;
  end

  // Other addresses belong to other blocks and read as zero here
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rd_data_out <= ADRS_RD_IDLE;
    else if (rd_strobe_in && status_hit)
      rd_data_out <= status_vec;
    else
      rd_data_out <= ADRS_RD_IDLE;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence set_complete_s;
    all_read && !any_acq && !any_over;
  endsequence

  sequence partial_read_s;
    all_ready && !all_read && !any_acq;
  endsequence

  sequence status_read_s;
    rd_strobe_in && (rd_addr_in == ADRS_STATUS_ADDR);
  endsequence

  x_ready_set_a: assert property (
    acq_done_in[0] |=> ready_flag[0] ##1 status_out[0])
    else $error("x ready not set after sample");

  y_ready_clr_a: assert property (
    hi_rd[1] && !acq_done_in[1] |=> !ready_flag[1])
    else $error("y ready not cleared by read");

  z_ready_set_a: assert property (
    acq_done_in[2] |=> ##1 status_out[2])
    else $error("z ready missing in status");

  z_over_set_a: assert property (
    acq_done_in[2] && ready_flag[2] && !hi_rd[2] |=> over_flag[2])
    else $error("z overwrite not flagged");

  y_over_set_a: assert property (
    acq_done_in[1] && ready_flag[1] && !hi_rd[1] |=> over_flag[1])
    else $error("y overwrite not flagged");

  x_over_clr_a: assert property (
    hi_rd[0] && !acq_done_in[0] |=> !over_flag[0])
    else $error("x overwrite not cleared by read");

  x_no_over_a: assert property (
    !ready_flag[0] && !over_flag[0] |=> !over_flag[0])
    else $error("x overwrite without prior sample");

  all_ready_set_a: assert property (
    any_acq |=> all_ready ##1 status_out[3])
    else $error("combined ready not set");

  all_over_set_a: assert property (
    over_evt[0] || over_evt[1] || over_evt[2] |=> all_over)
    else $error("combined overwrite not set");

  set_clear_a: assert property (
    set_complete_s |=> !all_ready && !all_over && rd_seen == 3'h0)
    else $error("combined flags not cleared by full set read");

  partial_keep_a: assert property (
    partial_read_s |=> all_ready)
    else $error("combined ready cleared before all reads");

  status_read_a: assert property (
    status_read_s and mode_off |=> rd_valid_out &&
      rd_data_out == $past(status_vec))
    else $error("status read returned wrong value");

  alias_off_a: assert property (
    status_read_s and !mode_off |=> rd_data_out == 8'h00)
    else $error("status visible while fifo mode active");

  reset_zero_a: assert property (@(posedge clock_in)
    !sys_rst_in && $past(sys_rst_in) |-> status_out == ADRS_STATUS_RST &&
      rd_data_out == ADRS_RD_IDLE && !rd_valid_out)
    else $error("status not zero after reset");
endmodule : adrs_status

// ==== include/adrs_pkg.sv ====
// Purpose: Constants for the accelerometer data-ready status block
// Assumes: Register reads arrive as one-cycle strobes with an address
// Notes: Axis order everywhere is 0 = X, 1 = Y, 2 = Z
package adrs_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADRS_STATUS_ADDR = 8'h00;
  localparam logic [7:0] ADRS_OUT_X_HI_ADDR = 8'h01;
  localparam logic [7:0] ADRS_OUT_Y_HI_ADDR = 8'h03;
  localparam logic [7:0] ADRS_OUT_Z_HI_ADDR = 8'h05;

  // ----------------------------------------------------------------
  // Mode, sizes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ADRS_FMODE_OFF = 2'h0;
  localparam int ADRS_NUM_AXES = 3;
  localparam logic [7:0] ADRS_STATUS_RST = 8'h00;
  localparam logic [7:0] ADRS_RD_IDLE = 8'h00;
  localparam logic [2:0] ADRS_SEEN_RST = 3'h0;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ADRS_BIT_READY_LO = 0;
  localparam int ADRS_BIT_ALL_READY = 3;
  localparam int ADRS_BIT_OVER_LO = 4;
  localparam int ADRS_BIT_ALL_OVER = 7;
endpackage : adrs_pkg

// ==== verilog/adrs_axis_flag.sv ====
// Purpose: Ready and overwrite flags of one acceleration axis
// Assumes: acq_in and hi_rd_in are one-cycle pulses
// Notes: A read in the same cycle as a new sample consumes the old one
`timescale 1ns/1ps
module adrs_axis_flag (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Events
  input wire logic acq_in,
  input wire logic hi_rd_in,
  // Flags
  output logic ready_out,
  output logic over_out,
  output logic over_evt_out
);
  import adrs_pkg::*;

  // ----------------------------------------------------------------
  // Flag logic
  // ----------------------------------------------------------------
  // Unread sample replaced by a new one
  assign over_evt_out = acq_in && ready_out && !hi_rd_in;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      ready_out <= 1'b0;
    else if (acq_in)
      ready_out <= 1'b1;
    else if (hi_rd_in)
      ready_out <= 1'b0;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      over_out <= 1'b0;
    else if (over_evt_out)
      over_out <= 1'b1;
    else if (hi_rd_in)
      over_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  axis_ready_hold_a: assert property (
    ready_out && !hi_rd_in |=> ready_out)
    else $error("axis ready lost without read");

  axis_over_hold_a: assert property (
    over_out && !hi_rd_in |=> over_out)
    else $error("axis overwrite lost without read");
endmodule : adrs_axis_flag

// ==== verif/adrs_host_model.sv ====
// Purpose: Host controller issuing register reads to the status block
// Assumes: Caller enters burst at a falling edge of clock_in
// Notes: Address shows the inverse of the last value between reads
`timescale 1ns/1ps
module adrs_host_model (
  // Clock
  input wire logic clock_in,
  // Read request
  output logic rd_strobe_out,
  output logic [7:0] rd_addr_out
);
  import adrs_pkg::*;

  initial
  begin
    rd_strobe_out = 1'b0;
    rd_addr_out = 8'hff;
  end

  // ----------------------------------------------------------------
  // Back-to-back reads, one byte per cycle
  // ----------------------------------------------------------------
  task burst(input logic [23:0] addrs, input int n);
    for (int i = 0; i < n; i++)
    begin
      rd_strobe_out = 1'b1;
      rd_addr_out = addrs[8*i+:8];
      @(negedge clock_in);
    end
    rd_strobe_out = 1'b0;
    rd_addr_out = ~rd_addr_out;
    // Idle cycle so a following burst never re-raises strobe at once
    @(negedge clock_in);
  endtask : burst
endmodule : adrs_host_model

// ==== verif/adrs_status_test.sv ====
// Purpose: Self-checking bench of the data-ready status block
// Assumes: Reference flags updated on the same edges as the design
// Notes: Directed corner cases first, then seeded random traffic
`timescale 1ns/1ps
module adrs_status_test;
  import adrs_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] acq = 3'h0;
  logic [1:0] mode = ADRS_FMODE_OFF;
  logic rd_strobe, rd_valid_out, status_live_out, live_q, v_q, chk_en = 0;
  logic [7:0] rd_addr, rd_data_out, status_out, est, st_q, rd_q;
  logic [2:0] rdy, ovr, seen, hi, owe;
  logic all_r, all_o, done3, rdall;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h22217e45;
  int r;

  always #20 clock_in = ~clock_in;

  adrs_status uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .acq_done_in(acq), .fifo_mode_in(mode), .rd_strobe_in(rd_strobe),
    .rd_addr_in(rd_addr), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .status_out(status_out),
    .status_live_out(status_live_out));
  adrs_host_model host (.clock_in(clock_in), .rd_strobe_out(rd_strobe),
    .rd_addr_out(rd_addr));

  // ----------------------------------------------------------------
  // Reference flags
  // ----------------------------------------------------------------
  assign hi = {3{rd_strobe}} & {rd_addr == ADRS_OUT_Z_HI_ADDR,
    rd_addr == ADRS_OUT_Y_HI_ADDR, rd_addr == ADRS_OUT_X_HI_ADDR};
  assign owe = acq & rdy & ~hi;
  assign rdall = ((seen | hi) == 3'h7);
  assign done3 = rdall && (acq == 3'h0);
  assign est = {all_o, ovr, all_r, rdy};
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      {rdy, ovr, seen, all_r, all_o} <= '0;
      {st_q, rd_q, v_q, live_q} <= '0;
    end
    else
    begin
      rdy <= acq | (rdy & ~hi);
      ovr <= owe | (ovr & ~hi);
      seen <= (acq != 3'h0) ? 3'h0 : (seen | hi);
      all_r <= (acq != 3'h0) | (all_r & ~done3);
      all_o <= (owe != 3'h0) | (all_o & ~rdall);
      st_q <= est;
      v_q <= rd_strobe;
      rd_q <= exp_rd(rd_strobe, rd_addr, mode, est);
      live_q <= (mode == ADRS_FMODE_OFF);
    end
  end

  // Expected read answer: status only at its address in mode off
  function automatic logic [7:0] exp_rd(input logic s, input logic [7:0] a,
    input logic [1:0] m, input logic [7:0] v);
    if (s && a == ADRS_STATUS_ADDR && m == ADRS_FMODE_OFF)
      return v;
    return ADRS_RD_IDLE;
  endfunction : exp_rd

  task cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : cmp

  always @(negedge clock_in)
  begin
    if (chk_en)
    begin
      cmp(status_out[7], st_q[7], "combined overwrite");
      cmp(status_out[6:4], st_q[6:4], "axis overwrite");
      cmp(status_out[3], st_q[3], "combined ready");
      cmp(status_out[2:0], st_q[2:0], "axis ready");
      cmp(rd_valid_out, v_q, "read valid");
      cmp(rd_data_out, rd_q, "read data");
      cmp(status_live_out, live_q, "live view");
    end
  end

  task pulse(input logic [2:0] a);
    acq = a;
    @(negedge clock_in);
    acq = 3'h0;
    @(negedge clock_in);
  endtask : pulse

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    #800000;
    err_total++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    test_done();
  end

  initial
  begin
    repeat (5) @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk_en = 1'b1;
    cmp(status_out, ADRS_STATUS_RST, "reset value");
    host.burst(24'h00, 1);
    $display("test reset done");
    pulse(3'h1);
    host.burst(24'h00, 1);
    pulse(3'h1);
    pulse(3'h6);
    pulse(3'h6);
    host.burst(24'h000301, 3);
    host.burst(24'h05, 1);
    pulse(3'h7);
    host.burst(24'h0301, 2);
    pulse(3'h2);
    host.burst(24'h000503, 3);
    host.burst(24'h0001, 2);
    // Sample and high read of the same axis in one cycle
    fork
      pulse(3'h1);
      host.burst(24'h01, 1);
    join
    host.burst(24'h00, 1);
    // Last high read of a set meets a sample on that axis
    pulse(3'h1);
    pulse(3'h1);
    host.burst(24'h0301, 2);
    fork
      pulse(3'h4);
      host.burst(24'h05, 1);
    join
    host.burst(24'h00, 1);
    $display("test walk done");
    mode = 2'h1;
    pulse(3'h4);
    host.burst(24'h000500, 3);
    mode = ADRS_FMODE_OFF;
    host.burst(24'h00, 1);
    $display("test mode done");
    for (int i = 0; i < 400; i++)
    begin
      r = $random(seed);
      if (r[7:6] == 2'h0)
        mode = r[9:8];
      if (i == 200)
      begin
        sys_rst_in = 1'b1;
        @(negedge clock_in);
        sys_rst_in = 1'b0;
      end
      if (r[0])
        pulse(r[3:1]);
      else
        host.burst({8'h00, (r[5:4] == 2'h0) ? 8'h00 : 8'h01,
          {5'h0, r[12:11], 1'b1}}, r[2] ? 3 : 1);
    end
    $display("test random done");
    repeat (2) @(negedge clock_in);
    test_done();
  end
endmodule : adrs_status_test
